/* rtl/monitor_alert_mask_pkg.sv */
// constants, reset values and field positions for the monitor alert/mask register slice
// assumes an external smbus front end that turns bus cycles into one-cycle register strobes
`default_nettype none

package monitor_alert_mask_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_MASK_FIRST = 8'h74;
    localparam logic [7:0] ADDR_MASK_SECOND = 8'h75;
    localparam logic [7:0] ADDR_LOW_FIRST = 8'h76;
    localparam logic [7:0] ADDR_LOW_SECOND = 8'h77;
    localparam logic [7:0] ADDR_PIN_FAN_SPEED_PULSE_INPUT = 8'h78;
    localparam logic [7:0] ADDR_PULSE_CFG = 8'h7B;

    // ==========================================================
    // reset values
    localparam logic [7:0] MASK_FIRST_RST = 8'h00;
    localparam logic [7:0] MASK_SECOND_RST = 8'h00;
    localparam logic [7:0] PIN_FAN_SPEED_PULSE_INPUT_RST = 8'h00;
    localparam logic [7:0] PULSE_CFG_RST = 8'h55;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // field positions
    localparam int SECOND_MASK_GATE_BIT = 7;
    localparam int OVERTEMP_MASK_BIT = 1;
    localparam int ALERT_MODE_BIT = 0;
    localparam int FAST_FAN_SPEED_PULSE_INPUT_BIT = 3;
    localparam int CONT_SPEED_LSB = 4;
    localparam int CHANNELS = 8;
    localparam int FANS = 4;

    // ==========================================================
    // fan_speed_pulse_input interval timing at a 20 MHz system clock
    localparam int CLK_KHZ = 20000;
    localparam int FAN_SPEED_PULSE_INPUT_SLOW_MS = 1000;
    localparam int FAN_SPEED_PULSE_INPUT_FAST_MS = 250;
    localparam int FAN_SPEED_PULSE_INPUT_SLOW_CYC = FAN_SPEED_PULSE_INPUT_SLOW_MS * CLK_KHZ;
    localparam int FAN_SPEED_PULSE_INPUT_FAST_CYC = FAN_SPEED_PULSE_INPUT_FAST_MS * CLK_KHZ;
    localparam int TIMER_W = 25;

    // pulse field code to pulse count, 00 -> 1 .. 11 -> 4
    function automatic logic [2:0] pulses_counted(input logic [1:0] field);
        pulses_counted = {1'b0, field} + 3'h1;
    endfunction

endpackage

`default_nettype wire

/* rtl/alert_source_combiner.sv */
// combines fault sources with the two mask registers into one pending level
// assumes fault inputs are levels on clk_sys_i, held by the status logic until cleared
`default_nettype none

module alert_source_combiner
    import monitor_alert_mask_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // masks
    input wire logic [7:0] mask_first_i,
    input wire logic [7:0] mask_second_i,
    // fault levels
    input wire logic [6:0] limit_fault_i,
    input wire logic [7:0] other_fault_i,
    // result
    output logic alert_pending_o
);

    logic [7:0] eff_second;
    logic [6:0] live_first;
    logic [7:0] live_second;

    // second register ignored entirely unless the gate bit is set
    assign eff_second = mask_first_i[SECOND_MASK_GATE_BIT] ? mask_second_i : 8'h00;
    assign live_first = limit_fault_i & ~mask_first_i[6:0];
    // bit0 12 V, bit1 overtemp, bits2..5 fans, bits6..7 diodes
    assign live_second = other_fault_i & ~eff_second;

    // registered so the pin never glitches on mask writes
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alert_pending_o <= 1'b0;
        end else begin
            alert_pending_o <= (|live_first) | (|live_second);
        end
    end

endmodule

`default_nettype wire

/* rtl/fan_speed_pulse_input_interval_timer.sv */
// free-running timer giving one pulse per fan_speed_pulse_input measurement interval
// assumes period values at least 2; restarts whenever the rate select changes
`default_nettype none

module fan_speed_pulse_input_interval_timer
    import monitor_alert_mask_pkg::*;
#(
    parameter int SLOW_CYC = FAN_SPEED_PULSE_INPUT_SLOW_CYC,
    parameter int FAST_CYC = FAN_SPEED_PULSE_INPUT_FAST_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // rate select
    input wire logic fast_i,
    // interval pulse
    output logic tick_o
);

    localparam logic [TIMER_W-1:0] SLOW_LAST = TIMER_W'(SLOW_CYC - 1);
    localparam logic [TIMER_W-1:0] FAST_LAST = TIMER_W'(FAST_CYC - 1);

    logic [TIMER_W-1:0] count;
    logic fast_q;
    logic [TIMER_W-1:0] last;

    assign last = fast_i ? FAST_LAST : SLOW_LAST;

    // a rate change restarts the interval so no short first period is seen
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            count <= '0;
            fast_q <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            fast_q <= fast_i;
            tick_o <= 1'b0;
            if (fast_q != fast_i) begin
                count <= '0;
            end else if (count >= last) begin
                count <= '0;
                tick_o <= 1'b1;
            end else begin
                count <= count + TIMER_W'(1);
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/monitor_alert_mask_regs.sv */
// register slice: alert masks, low result bits with coherent freeze, pin and fan_speed_pulse_input config
// assumes reg strobes come one cycle wide from the smbus front end on clk_sys_i,
// and that upper-byte result registers live outside and honour result_freeze_o
`default_nettype none

module monitor_alert_mask_regs
    import monitor_alert_mask_pkg::*;
#(
    parameter int FAN_SPEED_PULSE_INPUT_SLOW_CYCLES = FAN_SPEED_PULSE_INPUT_SLOW_CYC,
    parameter int FAN_SPEED_PULSE_INPUT_FAST_CYCLES = FAN_SPEED_PULSE_INPUT_FAST_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // register access from the smbus front end
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wr_data_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rd_data_o,
    // measurement engine
    input wire logic [15:0] meas_low_bits_i,
    input wire logic [7:0] upper_byte_read_i,
    output logic [7:0] result_freeze_o,
    // fault levels from the limit comparators and status logic
    input wire logic [6:0] limit_fault_i,
    input wire logic [7:0] other_fault_i,
    // fan drive two pin, shared with the alert function
    input wire logic fan_drive_wave_i,
    output logic fan_drive_two_pin_o,
    output logic fan_drive_two_pin_oe_o,
    // fan_speed_pulse_input measurement control
    output logic fan_speed_pulse_input_interval_tick_o,
    output logic [3:0] continuous_speed_o,
    output logic [11:0] fan_speed_pulse_input_pulse_count_o
);

    // ==========================================================
    // local constants and helpers
    // decoded counts that go with the reset value of the pulse register,
    // so the counts stay legal (1..4) even while reset is held
    localparam logic [11:0] PULSE_COUNT_RST = {
        pulses_counted(PULSE_CFG_RST[7:6]),
        pulses_counted(PULSE_CFG_RST[5:4]),
        pulses_counted(PULSE_CFG_RST[3:2]),
        pulses_counted(PULSE_CFG_RST[1:0])
    };

    // one strobe aimed at one address; exact compare, so no aliasing
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        reg_hit = strobe && (addr == target);
    endfunction

    // ==========================================================
    // storage
    logic [7:0] alert_mask_first;
    logic [7:0] alert_mask_second;
    logic [7:0] voltage_low_bits;
    logic [7:0] mixed_low_bits;
    logic [7:0] pin_and_fan_speed_pulse_input_config;
    logic [7:0] fan_pulse_count_config;
    logic [7:0] freeze_pending;
    logic [7:0] next_freeze_pending;
    logic [7:0] next_rd_data;
    logic rd_low_first;
    logic rd_low_second;
    logic wr_mask_first;
    logic wr_mask_second;
    logic wr_pin_fan_speed_pulse_input;
    logic wr_pulse_cfg;
    logic alert_pending;
    logic tick;
    // named fields of the config and low-bit registers
    logic alert_pin_mode;
    logic fast_fan_speed_pulse_input_rate;
    logic continuous_speed_one;
    logic continuous_speed_two;
    logic continuous_speed_three;
    logic continuous_speed_four;
    logic [1:0] two_five_volt_low_bits;
    logic [1:0] cpu_core_supply_low_bits;
    logic [1:0] supply_low_bits;
    logic [1:0] five_volt_low_bits;
    logic [1:0] twelve_volt_low_bits;
    logic [1:0] remote_one_low_bits;
    logic [1:0] local_temp_low_bits;
    logic [1:0] remote_two_low_bits;

    // ==========================================================
    // address decode
    assign rd_low_first = reg_hit(reg_rd_i, reg_addr_i, ADDR_LOW_FIRST);
    assign rd_low_second = reg_hit(reg_rd_i, reg_addr_i, ADDR_LOW_SECOND);
    assign wr_mask_first = reg_hit(reg_wr_i, reg_addr_i, ADDR_MASK_FIRST);
    assign wr_mask_second = reg_hit(reg_wr_i, reg_addr_i, ADDR_MASK_SECOND);
    assign wr_pin_fan_speed_pulse_input = reg_hit(reg_wr_i, reg_addr_i, ADDR_PIN_FAN_SPEED_PULSE_INPUT);
    assign wr_pulse_cfg = reg_hit(reg_wr_i, reg_addr_i, ADDR_PULSE_CFG);

    // ==========================================================
    // field views
    // pin mode, fan_speed_pulse_input rate and continuous enables of the config register
    // reserved config bits 1 and 2 have no view; they are only stored
    assign alert_pin_mode = pin_and_fan_speed_pulse_input_config[ALERT_MODE_BIT];
    assign fast_fan_speed_pulse_input_rate = pin_and_fan_speed_pulse_input_config[FAST_FAN_SPEED_PULSE_INPUT_BIT];
    assign continuous_speed_one = pin_and_fan_speed_pulse_input_config[CONT_SPEED_LSB];
    assign continuous_speed_two = pin_and_fan_speed_pulse_input_config[CONT_SPEED_LSB + 1];
    assign continuous_speed_three = pin_and_fan_speed_pulse_input_config[CONT_SPEED_LSB + 2];
    assign continuous_speed_four = pin_and_fan_speed_pulse_input_config[CONT_SPEED_LSB + 3];

    // two low bits per channel, in the channel order of the live input
    assign two_five_volt_low_bits = voltage_low_bits[1:0];
    assign cpu_core_supply_low_bits = voltage_low_bits[3:2];
    assign supply_low_bits = voltage_low_bits[5:4];
    assign five_volt_low_bits = voltage_low_bits[7:6];
    assign twelve_volt_low_bits = mixed_low_bits[1:0];
    assign remote_one_low_bits = mixed_low_bits[3:2];
    assign local_temp_low_bits = mixed_low_bits[5:4];
    assign remote_two_low_bits = mixed_low_bits[7:6];

    // ==========================================================
    // alert mask registers
    // first mask register, all eight bits writable
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alert_mask_first <= MASK_FIRST_RST;
        end else if (wr_mask_first) begin
            alert_mask_first <= reg_wr_data_i;
        end
    end

    // second mask register; the overtemp mask bit keeps its value on writes
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alert_mask_second <= MASK_SECOND_RST;
        end else if (wr_mask_second) begin
            alert_mask_second[0] <= reg_wr_data_i[0];
            alert_mask_second[5:2] <= reg_wr_data_i[5:2];
            alert_mask_second[7:6] <= reg_wr_data_i[7:6];
        end
    end
    // bit 1 is never written, so it holds its reset value

    // ==========================================================
    // coherent freeze of low and upper result bits
    // channel order: 2.5 V, cpu core, supply, 5 V, 12 V, remote one, local, remote two
    // a new freeze set wins over an upper-byte read landing in the same cycle
    // limitation: a second low-bits read while frozen keeps the first snapshot
    always_comb begin
        next_freeze_pending = freeze_pending & ~upper_byte_read_i;
        if (rd_low_first) begin
            next_freeze_pending[3:0] = 4'hF;
        end
        if (rd_low_second) begin
            next_freeze_pending[7:4] = 4'hF;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            freeze_pending <= 8'h00;
        end else begin
            freeze_pending <= next_freeze_pending;
        end
    end

    // freeze flags out to the upper-byte registers straight from flops
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            result_freeze_o <= 8'h00;
        end else begin
            result_freeze_o <= next_freeze_pending;
        end
    end

    // low bits follow the engine until frozen; the read cycle itself freezes too,
    // so the snapshot the host saw is the one that stays
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            voltage_low_bits <= 8'h00;
        end else if (~|next_freeze_pending[3:0]) begin
            voltage_low_bits <= meas_low_bits_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mixed_low_bits <= 8'h00;
        end else if (~|next_freeze_pending[7:4]) begin
            mixed_low_bits <= meas_low_bits_i[15:8];
        end
    end

    // ==========================================================
    // pin and fan_speed_pulse_input configuration
    // reserved bits 1 and 2 are simply stored and read back
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pin_and_fan_speed_pulse_input_config <= PIN_FAN_SPEED_PULSE_INPUT_RST;
        end else if (wr_pin_fan_speed_pulse_input) begin
            pin_and_fan_speed_pulse_input_config <= reg_wr_data_i;
        end
    end

    // pulse count fields, one pair of bits per fan
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fan_pulse_count_config <= PULSE_CFG_RST;
        end else if (wr_pulse_cfg) begin
            fan_pulse_count_config <= reg_wr_data_i;
        end
    end

    // ==========================================================
    // read path
    // low-bit registers are read from their frozen snapshot; unmapped reads give zero
    // the snapshot is rebuilt from its channel fields, same order as the live input
    always_comb begin
        unique case (reg_addr_i)
            ADDR_MASK_FIRST: next_rd_data = alert_mask_first;
            ADDR_MASK_SECOND: next_rd_data = alert_mask_second;
            ADDR_LOW_FIRST: next_rd_data = {five_volt_low_bits, supply_low_bits, cpu_core_supply_low_bits,
                two_five_volt_low_bits};
            ADDR_LOW_SECOND: next_rd_data = {remote_two_low_bits, local_temp_low_bits, remote_one_low_bits,
                twelve_volt_low_bits};
            ADDR_PIN_FAN_SPEED_PULSE_INPUT: next_rd_data = pin_and_fan_speed_pulse_input_config;
            ADDR_PULSE_CFG: next_rd_data = fan_pulse_count_config;
            default: next_rd_data = READ_UNMAPPED;
        endcase
    end

    // data appears the cycle after the read strobe and holds until the next read
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rd_data_o <= READ_UNMAPPED;
        end else if (reg_rd_i) begin
            reg_rd_data_o <= next_rd_data;
        end
    end

    // ==========================================================
    // alert generation
    alert_source_combiner u_alert (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .mask_first_i(alert_mask_first),
        .mask_second_i(alert_mask_second),
        .limit_fault_i(limit_fault_i),
        .other_fault_i(other_fault_i),
        .alert_pending_o(alert_pending)
    );

    // shared pin: open drain low for alert, else push-pull fan waveform.
    // one cycle of register delay on the waveform is the price of a flop output
    // alert mode only ever pulls low, so the shared pull-up sees a clean wired line
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fan_drive_two_pin_o <= 1'b0;
            fan_drive_two_pin_oe_o <= 1'b1;
        end else if (alert_pin_mode) begin
            fan_drive_two_pin_o <= 1'b0;
            fan_drive_two_pin_oe_o <= alert_pending;
        end else begin
            fan_drive_two_pin_o <= fan_drive_wave_i;
            fan_drive_two_pin_oe_o <= 1'b1;
        end
    end

    // ==========================================================
    // fan_speed_pulse_input measurement control
    // a rate change restarts the interval in the timer, so no short period follows it
    fan_speed_pulse_input_interval_timer #(
        .SLOW_CYC(FAN_SPEED_PULSE_INPUT_SLOW_CYCLES),
        .FAST_CYC(FAN_SPEED_PULSE_INPUT_FAST_CYCLES)
    ) u_fan_speed_pulse_input_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .fast_i(fast_fan_speed_pulse_input_rate),
        .tick_o(tick)
    );

    assign fan_speed_pulse_input_interval_tick_o = tick;

    // continuous enables, fan one in bit 0, registered for clean outputs
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            continuous_speed_o <= 4'h0;
        end else begin
            continuous_speed_o <= {continuous_speed_four, continuous_speed_three, continuous_speed_two,
                continuous_speed_one};
        end
    end

    // decoded pulse counts; a field change shows one cycle after the write lands
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fan_speed_pulse_input_pulse_count_o <= PULSE_COUNT_RST;
        end else begin
            for (int f = 0; f < FANS; f++) begin
                fan_speed_pulse_input_pulse_count_o[3*f +: 3] <= pulses_counted(fan_pulse_count_config[2*f +: 2]);
            end
        end
    end

endmodule

`default_nettype wire

/* dv/monitor_alert_host_model.sv */
// host-side model of the shared alert line and its pull-up
// assumes pin and enable come straight from the register slice
`default_nettype none
module monitor_alert_host_model (
    // pin from the device
    input wire logic pin_i,
    input wire logic oe_i,
    // level the host sees
    output logic alert_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // released line floats to the pull-up, never to x
    assign alert_line_o = oe_i ? pin_i : 1'b1;
endmodule
`default_nettype wire

/* dv/monitor_alert_mask_props.sv */
// properties of the register port, freeze, pin and fan_speed_pulse_input outputs
// assumes it is bound to monitor_alert_mask_regs
`default_nettype none
module monitor_alert_mask_props
    import monitor_alert_mask_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wr_data_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rd_data_o,
    // freeze and pin
    input wire logic [7:0] upper_byte_read_i,
    input wire logic [7:0] result_freeze_o,
    input wire logic fan_drive_wave_i,
    input wire logic fan_drive_two_pin_o,
    input wire logic fan_drive_two_pin_oe_o,
    // fan_speed_pulse_input
    input wire logic fan_speed_pulse_input_interval_tick_o,
    input wire logic [3:0] continuous_speed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // ==========================================
    // helpers
    logic alert_mode;
    logic mapped;
    assign mapped = reg_addr_i inside {[8'h74:8'h78], 8'h7B};
    // shadow of the pin mode bit, same timing as the register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alert_mode <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == ADDR_PIN_FAN_SPEED_PULSE_INPUT) begin
            alert_mode <= reg_wr_data_i[ALERT_MODE_BIT];
        end
    end
    sequence s_rd(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    // ==========================================
    // properties
    a_unmapped_read_zero: assert property (reg_rd_i && !mapped |=> reg_rd_data_o == READ_UNMAPPED)
        else $error("unmapped read not zero");
    a_rd_data_stands: assert property (!reg_rd_i |=> $stable(reg_rd_data_o))
        else $error("read data moved without a read");
    a_overtemp_mask_ro: assert property (s_rd(ADDR_MASK_SECOND) |=> !reg_rd_data_o[OVERTEMP_MASK_BIT])
        else $error("overtemp mask bit not zero");
    a_freeze_first_set: assert property (s_rd(ADDR_LOW_FIRST) |=> result_freeze_o[3:0] == 4'hF)
        else $error("first freeze group not set");
    a_freeze_second_set: assert property (s_rd(ADDR_LOW_SECOND) |=> result_freeze_o[7:4] == 4'hF)
        else $error("second freeze group not set");
    a_freeze_upper_release: assert property (!reg_rd_i && upper_byte_read_i != 8'h00 |=>
        (result_freeze_o & $past(upper_byte_read_i)) == 8'h00) else $error("freeze not released");
    a_fan_mode_wave: assert property (!alert_mode |=> fan_drive_two_pin_oe_o &&
        fan_drive_two_pin_o == $past(fan_drive_wave_i)) else $error("fan mode pin wrong");
    a_alert_open_drain: assert property (alert_mode |=> !(fan_drive_two_pin_oe_o && fan_drive_two_pin_o))
        else $error("alert pin driven high");
    a_tick_single_pulse: assert property (fan_speed_pulse_input_interval_tick_o |=> !fan_speed_pulse_input_interval_tick_o [*8])
        else $error("fan_speed_pulse_input ticks too close");
    property p_cont;
        logic [3:0] d;
        (reg_wr_i && reg_addr_i == ADDR_PIN_FAN_SPEED_PULSE_INPUT, d = reg_wr_data_i[7:4]) |-> ##2 continuous_speed_o == d;
    endproperty
    a_continuous_follows: assert property (p_cont)
        else $error("continuous enables wrong");
endmodule
bind monitor_alert_mask_regs monitor_alert_mask_props i_props (.clk_sys_i, .srst_i, .reg_addr_i,
    .reg_wr_i, .reg_wr_data_i, .reg_rd_i, .reg_rd_data_o, .upper_byte_read_i, .result_freeze_o,
    .fan_drive_wave_i, .fan_drive_two_pin_o, .fan_drive_two_pin_oe_o, .fan_speed_pulse_input_interval_tick_o,
    .continuous_speed_o);
`default_nettype wire

/* dv/test_monitor_alert_mask_regs.sv */
// self-checking bench for the alert mask register slice
// assumes short fan_speed_pulse_input periods so the rate check fits a short run
`default_nettype none
module test_monitor_alert_mask_regs;
    import monitor_alert_mask_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLOW = 40;
    localparam int FAST = 10;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic fan_drive_wave_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wr_data_i = 8'h00;
    logic [7:0] upper_byte_read_i = 8'h00;
    logic [7:0] other_fault_i = 8'h00;
    logic [6:0] limit_fault_i = 7'h00;
    logic [15:0] meas_low_bits_i = 16'h0000;
    logic [7:0] reg_rd_data_o, result_freeze_o, rdv, m1, m2, d, a;
    logic fan_drive_two_pin_o, fan_drive_two_pin_oe_o, fan_speed_pulse_input_interval_tick_o, alert_line;
    logic [3:0] continuous_speed_o;
    logic [11:0] fan_speed_pulse_input_pulse_count_o;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    logic [7:0] reset_addrs [5] = '{8'h74, 8'h75, 8'h78, 8'h7B, 8'h7A};
    logic [7:0] reset_vals [5] = '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00};
    monitor_alert_mask_regs #(.FAN_SPEED_PULSE_INPUT_SLOW_CYCLES(SLOW), .FAN_SPEED_PULSE_INPUT_FAST_CYCLES(FAST)) i_dut (.clk_sys_i, .srst_i,
        .reg_addr_i, .reg_wr_i, .reg_wr_data_i, .reg_rd_i, .reg_rd_data_o, .meas_low_bits_i,
        .upper_byte_read_i, .result_freeze_o, .limit_fault_i, .other_fault_i, .fan_drive_wave_i,
        .fan_drive_two_pin_o, .fan_drive_two_pin_oe_o, .fan_speed_pulse_input_interval_tick_o, .continuous_speed_o,
        .fan_speed_pulse_input_pulse_count_o);
    monitor_alert_host_model i_host (.pin_i(fan_drive_two_pin_o), .oe_i(fan_drive_two_pin_oe_o),
        .alert_line_o(alert_line));
    // ==========================================
    // clock, waveform, watchdog
    always #25 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) fan_drive_wave_i <= 1'($urandom);
    // a hang counts as a mismatch
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ==========================================
    // tasks and expectations
    task tally_and_finish();
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] v);
        @(negedge clk_sys_i);
        reg_addr_i = ad;
        reg_wr_data_i = v;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    // data lands on the same edge that takes the strobe
    task rd(input logic [7:0] ad);
        @(negedge clk_sys_i);
        reg_addr_i = ad;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        @(negedge clk_sys_i);
        rdv = reg_rd_data_o;
    endtask
    task gap(output int g);
        g = 0;
        while (fan_speed_pulse_input_interval_tick_o !== 1'b1) @(negedge clk_sys_i);
        do begin
            @(negedge clk_sys_i);
            g++;
        end while (fan_speed_pulse_input_interval_tick_o !== 1'b1);
    endtask
    function automatic logic [11:0] pcnt(input logic [7:0] v);
        logic [11:0] c;
        for (int i = 0; i < 4; i++) c[3*i+:3] = {1'b0, v[2*i+:2]} + 3'h1;
        return c;
    endfunction
    // overtemp mask cannot be set, so it never masks
    function automatic logic line_exp(input logic [7:0] f, s, input logic [14:0] flt);
        logic [7:0] sm;
        sm = f[7] ? (s & 8'hFD) : 8'h00;
        return !(|(flt[6:0] & ~f[6:0]) || |(flt[14:7] & ~sm));
    endfunction
    // ==========================================
    // main sequence
    initial begin
        n = $urandom(32330);
        repeat (5) @(negedge clk_sys_i);
        srst_i = 1'b0;
        foreach (reset_addrs[i]) begin
            rd(reset_addrs[i]);
            cmp("reset value", reset_vals[i], rdv);
        end
        cmp("pulse counts", 12'h492, fan_speed_pulse_input_pulse_count_o);
        for (int i = 0; i < 9; i++) begin
            d = (i == 0) ? 8'h1B : 8'($urandom);
            wr(ADDR_MASK_FIRST, d);
            rd(ADDR_MASK_FIRST);
            cmp("mask first", d, rdv);
            wr(ADDR_MASK_SECOND, d);
            rd(ADDR_MASK_SECOND);
            cmp("mask second", d & 8'hFD, rdv);
            wr(ADDR_PIN_FAN_SPEED_PULSE_INPUT, d & 8'hF6);
            rd(ADDR_PIN_FAN_SPEED_PULSE_INPUT);
            cmp("pin fan_speed_pulse_input config", d & 8'hF6, rdv);
            cmp("continuous", d[7:4], continuous_speed_o);
            wr(ADDR_PULSE_CFG, d);
            wr(8'h79, d);
            rd(ADDR_PULSE_CFG);
            cmp("pulse config", d, rdv);
            cmp("pulse counts", pcnt(d), fan_speed_pulse_input_pulse_count_o);
            rd(8'h79);
            cmp("unmapped", READ_UNMAPPED, rdv);
        end
        for (int f = 1; f >= 0; f--) begin
            wr(ADDR_PIN_FAN_SPEED_PULSE_INPUT, 8'(f << FAST_FAN_SPEED_PULSE_INPUT_BIT));
            gap(n);
            gap(n);
            cmp("tick period", 16'(f ? FAST : SLOW), 16'(n));
        end
        wr(ADDR_PIN_FAN_SPEED_PULSE_INPUT, 8'h01);
        for (int p = 0; p < 30; p++) begin
            m1 = 8'($urandom);
            m2 = 8'($urandom);
            wr(ADDR_MASK_FIRST, m1);
            wr(ADDR_MASK_SECOND, m2);
            {other_fault_i, limit_fault_i} = 15'h1 << (p % 15);
            repeat (3) @(negedge clk_sys_i);
            cmp("alert line", line_exp(m1, m2, 15'h1 << (p % 15)), alert_line);
        end
        {other_fault_i, limit_fault_i} = 15'h0;
        wr(ADDR_PIN_FAN_SPEED_PULSE_INPUT, 8'h00);
        for (int k = 0; k < 2; k++) begin
            a = k ? ADDR_LOW_SECOND : ADDR_LOW_FIRST;
            meas_low_bits_i = 16'($urandom);
            repeat (3) @(negedge clk_sys_i);
            d = meas_low_bits_i[8*k+:8];
            rd(a);
            cmp("low bits", d, rdv);
            cmp("freeze set", 4'hF, result_freeze_o[4*k+:4]);
            meas_low_bits_i = ~meas_low_bits_i;
            repeat (3) @(negedge clk_sys_i);
            rd(a);
            cmp("low bits frozen", d, rdv);
            for (int j = 0; j < 4; j++) begin
                @(negedge clk_sys_i);
                upper_byte_read_i = 8'h01 << (4 * k + j);
                @(negedge clk_sys_i);
                upper_byte_read_i = 8'h00;
            end
            repeat (2) @(negedge clk_sys_i);
            cmp("freeze cleared", 4'h0, result_freeze_o[4*k+:4]);
            rd(a);
            cmp("low bits resumed", meas_low_bits_i[8*k+:8], rdv);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
